// ===== oscl_pkg.sv
// Package: constants for the clock source control write lock
package oscl_pkg;
  localparam int          OSCL_DW          = 8;
  localparam int          OSCL_AW          = 8;
  localparam logic [7:0]  OSCL_KEY_FIRST   = 8'he7;
  localparam logic [7:0]  OSCL_KEY_SECOND  = 8'h18;
  localparam logic [7:0]  OSCL_CSC_ADDR    = 8'h86;
  localparam logic [7:0]  OSCL_CSC_RESET   = 8'ha0;
  typedef enum logic [1:0] {
    OSCL_LOCKED  = 2'b00,
    OSCL_KEY1_OK = 2'b01,
    OSCL_OPEN    = 2'b11
  } oscl_state_t;
endpackage

// ===== oscl_key_check.sv
// Key comparator: classifies a written byte against the unlock keys
`timescale 1ns/1ps
module oscl_key_check (
  // Written data
  input  wire logic [7:0] wdata,
  // Classification
  output wire logic       is_first,
  output wire logic       is_second
);
  import oscl_pkg::*;
  // Key value compares
  assign is_first  = (wdata == OSCL_KEY_FIRST);
  assign is_second = (wdata == OSCL_KEY_SECOND);
endmodule

// ===== oscl_lock.sv
// Write lock guarding the clock source control register
// Contract
// R1: Unlock needs first key then second key
// R2: Next write after keys stores and relocks
// R3: Other write patterns leave register unchanged
// R4: Keys may be nonconsecutive; reversed order rejected
// R5: Other register accesses never disturb lock
// R6: Wrong value while locking restarts sequence
`timescale 1ns/1ps
module oscl_lock #(
  parameter logic [oscl_pkg::OSCL_AW-1:0] CSC_ADDR  = oscl_pkg::OSCL_CSC_ADDR,
  parameter logic [oscl_pkg::OSCL_DW-1:0] CSC_RESET = oscl_pkg::OSCL_CSC_RESET
) (
  // Clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        rst_n,
  // Internal register write port
  input  wire logic                        wr_en,
  input  wire logic [oscl_pkg::OSCL_AW-1:0] wr_addr,
  input  wire logic [oscl_pkg::OSCL_DW-1:0] wr_data,
  // Register contents and lock status
  output logic      [oscl_pkg::OSCL_DW-1:0] clock_source_control,
  output logic                             unlocked,
  output logic      [1:0]                  lock_state
);
  import oscl_pkg::*;

  oscl_state_t         state_q;
  oscl_state_t         state_d;
  logic [OSCL_DW-1:0]  csc_q;
  logic [OSCL_DW-1:0]  csc_d;
  wire  logic          csc_wr;
  wire  logic          key_first;
  wire  logic          key_second;

  // Key classification
  oscl_key_check oscl_key_check_i (
    .wdata     (wr_data),
    .is_first  (key_first),
    .is_second (key_second)
  );

  // Only writes to our own address count
  assign csc_wr = wr_en && (wr_addr == CSC_ADDR); // [R5]

  // Next lock state
  always_comb begin
    state_d = state_q;
    if (csc_wr) begin
      case (state_q)
        OSCL_LOCKED:  state_d = key_first ? OSCL_KEY1_OK : OSCL_LOCKED;  // [R1] [R4] [R6]
        OSCL_KEY1_OK: state_d = key_second ? OSCL_OPEN : OSCL_LOCKED;    // [R1] [R4] [R6]
        OSCL_OPEN:    state_d = OSCL_LOCKED;                             // [R2]
        default:      state_d = OSCL_LOCKED;
      endcase
    end
  end

  // Data only lands when open
  assign csc_d = (csc_wr && state_q == OSCL_OPEN) ? wr_data : csc_q; // [R2] [R3]

  // State and register flops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= OSCL_LOCKED;
      csc_q   <= CSC_RESET;
    end else begin
      state_q <= state_d;
      csc_q   <= csc_d;
    end
  end

  // Outputs from flops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      clock_source_control <= CSC_RESET;
      unlocked             <= 1'b0;
      lock_state           <= OSCL_LOCKED;
    end else begin
      clock_source_control <= csc_d;
      unlocked             <= (state_d == OSCL_OPEN);
      lock_state           <= state_d;
    end
  end

  // Checks
  // First key advances from locked
  property p_first_key;
    @(posedge clk_sys) disable iff (!rst_n)
      (csc_wr && state_q == OSCL_LOCKED && key_first) |=> (state_q == OSCL_KEY1_OK);
  endproperty
  a_first_key: assert property (p_first_key) else $error("first key not taken"); // [R1]

  // Second key opens the lock
  property p_second_key;
    @(posedge clk_sys) disable iff (!rst_n)
      (csc_wr && state_q == OSCL_KEY1_OK && key_second) |=> (state_q == OSCL_OPEN);
  endproperty
  a_second_key: assert property (p_second_key) else $error("second key not taken"); // [R1]

  // Open write lands and relocks
  property p_store_relock;
    @(posedge clk_sys) disable iff (!rst_n)
      (csc_wr && state_q == OSCL_OPEN) |=> (csc_q == $past(wr_data) && state_q == OSCL_LOCKED
        && !unlocked && clock_source_control == $past(wr_data));
  endproperty
  a_store_relock: assert property (p_store_relock) else $error("open write not stored"); // [R2]

  // Register frozen unless open write
  property p_no_change;
    @(posedge clk_sys) disable iff (!rst_n)
      !(csc_wr && state_q == OSCL_OPEN) |=> $stable(csc_q);
  endproperty
  a_no_change: assert property (p_no_change) else $error("register changed while locked"); // [R3]

  // Second key alone is refused
  property p_reversed;
    @(posedge clk_sys) disable iff (!rst_n)
      (csc_wr && state_q == OSCL_LOCKED && key_second) |=> (state_q == OSCL_LOCKED);
  endproperty
  a_reversed: assert property (p_reversed) else $error("reversed key accepted"); // [R4]

  // Lock ignores everything but its own writes
  property p_other_access;
    @(posedge clk_sys) disable iff (!rst_n)
      !csc_wr |=> $stable(state_q);
  endproperty
  a_other_access: assert property (p_other_access) else $error("stray lock move"); // [R5]

  // Bad second key restarts
  property p_wrong_value;
    @(posedge clk_sys) disable iff (!rst_n)
      (csc_wr && state_q == OSCL_KEY1_OK && !key_second) |=> (state_q == OSCL_LOCKED);
  endproperty
  a_wrong_value: assert property (p_wrong_value) else $error("bad key did not restart"); // [R6]

  // Unlock only by second key
  property p_status;
    @(posedge clk_sys) disable iff (!rst_n)
      (!unlocked && !(csc_wr && state_q == OSCL_KEY1_OK && key_second)) |=> !unlocked;
  endproperty
  a_status: assert property (p_status) else $error("unlocked without second key"); // [R1]

  // Reset leaves register at default, locked
  property p_reset_out;
    @(posedge clk_sys)
      $rose(rst_n) |-> (clock_source_control == CSC_RESET && !unlocked
        && lock_state == OSCL_LOCKED);
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("reset value wrong"); // [R3]

  // First-key state only entered by first key
  property p_key1_entry;
    @(posedge clk_sys) disable iff (!rst_n)
      (state_q != OSCL_KEY1_OK && !(csc_wr && state_q == OSCL_LOCKED && key_first))
        |=> (state_q != OSCL_KEY1_OK);
  endproperty
  a_key1_entry: assert property (p_key1_entry) else $error("stray first-key entry"); // [R1]

  // Locked state keeps on a non-key write
  property p_locked_stays;
    @(posedge clk_sys) disable iff (!rst_n)
      (csc_wr && state_q == OSCL_LOCKED && !key_first) |=> (state_q == OSCL_LOCKED);
  endproperty
  a_locked_stays: assert property (p_locked_stays) else $error("locked state left"); // [R6]

  // Open state waits through other traffic
  property p_open_holds;
    @(posedge clk_sys) disable iff (!rst_n)
      (state_q == OSCL_OPEN && !csc_wr) |=> (state_q == OSCL_OPEN && unlocked);
  endproperty
  a_open_holds: assert property (p_open_holds) else $error("open state lost"); // [R5]

  // Half-done unlock waits for the second key
  property p_key1_holds;
    @(posedge clk_sys) disable iff (!rst_n)
      (state_q == OSCL_KEY1_OK && !csc_wr) |=> (state_q == OSCL_KEY1_OK);
  endproperty
  a_key1_holds: assert property (p_key1_holds) else $error("first key forgotten"); // [R4]

  // Output register frozen unless open write
  property p_out_frozen;
    @(posedge clk_sys) disable iff (!rst_n)
      !(csc_wr && state_q == OSCL_OPEN) |=> $stable(clock_source_control);
  endproperty
  a_out_frozen: assert property (p_out_frozen) else $error("output moved while locked"); // [R3]

  // No single write opens from locked
  property p_no_jump;
    @(posedge clk_sys) disable iff (!rst_n)
      (csc_wr && state_q == OSCL_LOCKED) |=> (state_q != OSCL_OPEN);
  endproperty
  a_no_jump: assert property (p_no_jump) else $error("opened without first key"); // [R4]

  // Writes elsewhere touch neither lock nor register
  property p_addr_filter;
    @(posedge clk_sys) disable iff (!rst_n)
      (wr_en && wr_addr != CSC_ADDR) |=> ($stable(state_q) && $stable(csc_q));
  endproperty
  a_addr_filter: assert property (p_addr_filter) else $error("foreign write leaked"); // [R5]

  // Idle bus holds every output
  property p_idle_hold;
    @(posedge clk_sys) disable iff (!rst_n)
      !wr_en |=> ($stable(lock_state) && $stable(clock_source_control) && $stable(unlocked));
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("outputs moved while idle"); // [R5]

  // Repeated first key restarts the sequence
  property p_repeat_first;
    @(posedge clk_sys) disable iff (!rst_n)
      (csc_wr && state_q == OSCL_KEY1_OK && key_first) |=> (state_q == OSCL_LOCKED);
  endproperty
  a_repeat_first: assert property (p_repeat_first) else $error("repeated key kept"); // [R6]

  // Second key shows on the status outputs
  property p_key2_out;
    @(posedge clk_sys) disable iff (!rst_n)
      (csc_wr && state_q == OSCL_KEY1_OK && key_second)
        |=> (unlocked && lock_state == OSCL_OPEN);
  endproperty
  a_key2_out: assert property (p_key2_out) else $error("unlock not shown"); // [R1]

  // Any own write while open relocks the outputs
  property p_relock_out;
    @(posedge clk_sys) disable iff (!rst_n)
      (unlocked && csc_wr) |=> (!unlocked && lock_state == OSCL_LOCKED);
  endproperty
  a_relock_out: assert property (p_relock_out) else $error("lock not restored"); // [R2]
endmodule

// ===== oscl_lock_tb.sv
// Self-checking bench for the clock source control write lock
`timescale 1ns/1ps
module oscl_lock_tb;
  import oscl_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        wr_en = 1'b0;
  logic [7:0]  wr_addr = 8'h00;
  logic [7:0]  wr_data = 8'h00;
  logic [7:0]  clock_source_control;
  logic        unlocked;
  logic [1:0]  lock_state;
  wire  [10:0] obs = {clock_source_control, lock_state, unlocked};
  logic [10:0] exp_q[$];
  logic [7:0]  ref_csc = OSCL_CSC_RESET;
  logic [1:0]  ref_st = OSCL_LOCKED;
  logic        taken = 1'b0;
  int          error_cnt = 0;
  int          checked = 0;
  int          cycles = 0;
  int          seed = 47;
  logic [7:0]  seq[16] = '{8'he7, 8'h18, 8'h5a, 8'h18, 8'he7, 8'h33, 8'he7, 8'h00,
                           8'h18, 8'h44, 8'he7, 8'he7, 8'h18, 8'h66, 8'h77, 8'hc3};

  // Clock
  always #2.5 clk_sys = ~clk_sys;

  oscl_lock oscl_lock_i (.clk_sys(clk_sys), .rst_n(rst_n), .wr_en(wr_en), .wr_addr(wr_addr),
    .wr_data(wr_data), .clock_source_control(clock_source_control), .unlocked(unlocked),
    .lock_state(lock_state));

  // Compare and count
  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic complete_run();
    if (error_cnt == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // One write, expected outcome noted first
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (a == OSCL_CSC_ADDR) begin
      case (ref_st)
        OSCL_LOCKED:  ref_st = (d == OSCL_KEY_FIRST) ? OSCL_KEY1_OK : OSCL_LOCKED;
        OSCL_KEY1_OK: ref_st = (d == OSCL_KEY_SECOND) ? OSCL_OPEN : OSCL_LOCKED;
        default: begin
          ref_csc = d;
          ref_st = OSCL_LOCKED;
        end
      endcase
    end
    exp_q.push_back({ref_csc, ref_st, ref_st == OSCL_OPEN});
    wr_en <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
    @(posedge clk_sys);
  endtask

  // Note taken writes, cut a hang short
  always @(posedge clk_sys) begin
    taken <= wr_en;
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      error_cnt++;
      complete_run();
    end
  end

  // Settled outputs against oldest note
  always @(negedge clk_sys) if (taken) check(obs, exp_q.pop_front());

  // Directed then random traffic
  initial begin
    int r;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    check({clock_source_control, lock_state, unlocked}, {OSCL_CSC_RESET, 3'b000});
    foreach (seq[i]) begin
      wr(OSCL_CSC_ADDR, seq[i]);
      wr(8'h3c ^ seq[i], 8'($random(seed)));
    end
    repeat (400) begin
      r = $random(seed);
      if (r[6]) begin
        wr_en <= 1'b0;
        @(posedge clk_sys);
      end
      wr(r[0] ? OSCL_CSC_ADDR : {r[15:9], 1'b1},
         r[2] ? OSCL_KEY_FIRST : (r[3] ? OSCL_KEY_SECOND : r[31:24]));
    end
    // Reset in mid-sequence drops a half-done unlock
    wr(OSCL_CSC_ADDR, 8'h00);
    wr(OSCL_CSC_ADDR, OSCL_KEY_FIRST);
    wr_en <= 1'b0;
    @(posedge clk_sys);
    rst_n <= 1'b0;
    ref_st = OSCL_LOCKED;
    ref_csc = OSCL_CSC_RESET;
    repeat (2) @(posedge clk_sys);
    check(obs, {OSCL_CSC_RESET, 3'b000});
    rst_n <= 1'b1;
    wr(OSCL_CSC_ADDR, OSCL_KEY_SECOND);
    wr(OSCL_CSC_ADDR, 8'h5a);
    wr_en <= 1'b0;
    repeat (3) @(posedge clk_sys);
    complete_run();
  end
endmodule
